// ### rtl/stp_map.vh
`ifndef STP_MAP_VH
`define STP_MAP_VH
// register word indices, byte address = index * 4 (index = parameter number)
`define STP_IDX_BRAKE      8'd33
`define STP_IDX_INERTIA    8'd34
`define STP_IDX_PGAIN2     8'd35
`define STP_IDX_VGAIN1     8'd36
`define STP_IDX_VGAIN2     8'd37
`define STP_IDX_VINT       8'd38
`define STP_IDX_VDIFF      8'd39
`define STP_IDX_RSVA       8'd40
`define STP_IDX_RSVB       8'd41
`define STP_IDX_HOMEPOS    8'd42
`define STP_IDX_DOGTRAV    8'd43
`define STP_IDX_DWELL      8'd44
`define STP_IDX_TRQCAP     8'd45
`define STP_IDX_CTRL       8'd60
`define STP_IDX_STATUS     8'd61
`define STP_IDX_TUNE_INER  8'd62
`define STP_IDX_TUNE_PG2   8'd63
`define STP_IDX_TUNE_VG1   8'd64
`define STP_IDX_TUNE_VG2   8'd65
`define STP_IDX_TUNE_VIC   8'd66
// reset values
`define STP_RST_BRAKE      16'h0064
`define STP_RST_INERTIA    16'h0046
`define STP_RST_PGAIN2     16'h001E
`define STP_RST_VGAIN1     16'h00D8
`define STP_RST_VGAIN2     16'h02CA
`define STP_RST_VINT       16'h0014
`define STP_RST_VDIFF      16'h03D4
`define STP_RST_HOMEPOS    16'h0000
`define STP_RST_DOGTRAV    16'h03E8
`define STP_RST_DWELL      16'h0064
`define STP_RST_TRQCAP     16'h000F
// setting ranges
`define STP_MAX_BRAKE      16'h03E8
`define STP_MIN_INERTIA    16'h0000
`define STP_MAX_INERTIA    16'h03E8
`define STP_MIN_PGAIN2     16'h0001
`define STP_MAX_PGAIN2     16'h01F4
`define STP_MIN_VGAIN1     16'h0014
`define STP_MAX_VGAIN1     16'h1388
`define STP_MIN_VGAIN2     16'h0014
`define STP_MAX_VGAIN2     16'h1F40
`define STP_MIN_VINT       16'h0001
`define STP_MAX_VINT       16'h03E8
`define STP_MAX_VDIFF      16'h03E8
`define STP_MIN_DWELL      16'h0005
`define STP_MAX_DWELL      16'h03E8
`define STP_MIN_TRQCAP     16'h0001
`define STP_MAX_TRQCAP     16'h0064
// control bits
`define STP_CTRL_AUTOTUNE  0
`define STP_CTRL_STOPPER   1
`define STP_CTRL_HOMESTART 2
// timing: 1 ms at 50 MHz
`define STP_CLK_MHZ        50
`define STP_MS_CYCLES      (1000 * `STP_CLK_MHZ)
`endif

// ### rtl/stp_ms_timer.v
`include "stp_map.vh"
// ----------------------------------------
// millisecond countdown
// ----------------------------------------
module stp_ms_timer #(
  parameter MS_CYCLES = `STP_MS_CYCLES
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // control
  input  wire        start,
  input  wire        abort,
  input  wire [15:0] ms_count,
  // result
  output reg         busy,
  output reg         done
);
  reg [16:0] tick;
  reg [15:0] remain;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick   <= 17'h00000;
      remain <= 16'h0000;
      busy   <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
      end else if (start) begin
        tick <= 17'h00000;
        if (ms_count == 16'h0000) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          remain <= ms_count;
          busy   <= 1'b1;
        end
      end else if (busy) begin
        if (tick == MS_CYCLES - 1) begin
          tick <= 17'h00000;
          if (remain == 16'h0001) begin
            busy <= 1'b0;
            done <= 1'b1;
          end
          remain <= remain - 16'h0001;
        end else begin
          tick <= tick + 17'h00001;
        end
      end
    end
  end
endmodule // stp_ms_timer

// ### rtl/stp_servo_params.v
// What this block does
// - wait brake delay, then shut base circuit
// - hold inertia ratio, 0..1000, default 70
// - hold position gain 2, 1..500, default 30
// - hold speed gain 1, 20..5000, default 216
// - hold speed gain 2, 20..8000, default 714
// - hold integral time, 1..1000, default 20
// - apply differential comp only with proportion control
// - auto tuning overwrites the five loop values
// - home complete loads position with home data
// - count type travels programmed distance after dog
// - stopper type waits dwell after torque reached
// - stopper type limits torque to programmed percentage
`include "stp_map.vh"
module stp_servo_params #(
  parameter MS_CYCLES = `STP_MS_CYCLES
) (
  // apb
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // brake
  input  wire        brake_interlock_out,
  output reg         base_shutoff,
  // proportion control
  input  wire        proportion_control_in,
  output reg  [15:0] diff_comp_applied,
  // auto tuning results
  input  wire        tune_valid,
  input  wire [15:0] tune_inertia,
  input  wire [15:0] tune_pgain2,
  input  wire [15:0] tune_vgain1,
  input  wire [15:0] tune_vgain2,
  input  wire [15:0] tune_vint,
  // home return
  input  wire        dog_detected,
  input  wire        travel_pulse,
  input  wire        torque_reached,
  output reg         homing_busy,
  output reg         torque_limit_en,
  output reg  [15:0] torque_limit_pct,
  output reg         home_set,
  output reg  [15:0] current_position,
  // applied loop values
  output reg  [15:0] inertia_ratio_setting,
  output reg  [15:0] position_gain_second,
  output reg  [15:0] speed_gain_first,
  output reg  [15:0] speed_gain_second,
  output reg  [15:0] speed_integral_time
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [15:0] brake_release_delay;
  reg [15:0] speed_differential_comp;
  reg [15:0] home_position_value;
  reg [15:0] post_dog_travel;
  reg [15:0] stopper_dwell_time;
  reg [15:0] stopper_torque_cap;
  reg [2:0]  ctrl;
  reg [15:0] travel_left;
  reg        brake_prev;
  reg [15:0] last_tune_inertia;
  reg [15:0] last_tune_pgain2;
  reg [15:0] last_tune_vgain1;
  reg [15:0] last_tune_vgain2;
  reg [15:0] last_tune_vint;

  localparam ST_IDLE  = 4'b0001;
  localparam ST_SEEK  = 4'b0010;
  localparam ST_TRAVL = 4'b0100;
  localparam ST_DWELL = 4'b1000;
  reg [3:0] state;

  wire [7:0]  idx    = paddr[9:2];
  wire        wr     = psel & penable & pwrite;
  wire        rd_ph  = psel & ~penable & ~pwrite;
  wire [15:0] wv     = pwdata[15:0];
  wire        hi_ok  = (pwdata[31:16] == 16'h0000);
  wire        tuning = ctrl[`STP_CTRL_AUTOTUNE];

  wire brake_done;
  wire brake_busy;
  wire dwell_done;
  wire dwell_busy;

  // ----------------------------------------
  // apb slave, one wait-free access phase
  // ----------------------------------------
  reg        mapped;
  reg [15:0] rdv;
  always @* begin
    mapped = 1'b1;
    rdv    = 16'h0000;
    case (idx)
      `STP_IDX_BRAKE:     rdv = brake_release_delay;
      `STP_IDX_INERTIA:   rdv = inertia_ratio_setting;
      `STP_IDX_PGAIN2:    rdv = position_gain_second;
      `STP_IDX_VGAIN1:    rdv = speed_gain_first;
      `STP_IDX_VGAIN2:    rdv = speed_gain_second;
      `STP_IDX_VINT:      rdv = speed_integral_time;
      `STP_IDX_VDIFF:     rdv = speed_differential_comp;
      `STP_IDX_RSVA:      rdv = 16'h0000;
      `STP_IDX_RSVB:      rdv = 16'h0000;
      `STP_IDX_HOMEPOS:   rdv = home_position_value;
      `STP_IDX_DOGTRAV:   rdv = post_dog_travel;
      `STP_IDX_DWELL:     rdv = stopper_dwell_time;
      `STP_IDX_TRQCAP:    rdv = stopper_torque_cap;
      `STP_IDX_CTRL:      rdv = {13'h0000, ctrl};
      `STP_IDX_STATUS:    rdv = {11'h000, home_set, homing_busy, torque_limit_en, brake_busy, base_shutoff};
      `STP_IDX_TUNE_INER: rdv = last_tune_inertia;
      `STP_IDX_TUNE_PG2:  rdv = last_tune_pgain2;
      `STP_IDX_TUNE_VG1:  rdv = last_tune_vgain1;
      `STP_IDX_TUNE_VG2:  rdv = last_tune_vgain2;
      `STP_IDX_TUNE_VIC:  rdv = last_tune_vint;
      default:            mapped = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00 || paddr[11:10] != 2'b00) begin
      mapped = 1'b0;
    end
  end

  // range check per parameter
  reg in_range;
  always @* begin
    in_range = hi_ok;
    case (idx)
      `STP_IDX_BRAKE:   in_range = hi_ok && wv <= `STP_MAX_BRAKE;
      `STP_IDX_INERTIA: in_range = hi_ok && wv >= `STP_MIN_INERTIA && wv <= `STP_MAX_INERTIA;
      `STP_IDX_PGAIN2:  in_range = hi_ok && wv >= `STP_MIN_PGAIN2 && wv <= `STP_MAX_PGAIN2;
      `STP_IDX_VGAIN1:  in_range = hi_ok && wv >= `STP_MIN_VGAIN1 && wv <= `STP_MAX_VGAIN1;
      `STP_IDX_VGAIN2:  in_range = hi_ok && wv >= `STP_MIN_VGAIN2 && wv <= `STP_MAX_VGAIN2;
      `STP_IDX_VINT:    in_range = hi_ok && wv >= `STP_MIN_VINT && wv <= `STP_MAX_VINT;
      `STP_IDX_VDIFF:   in_range = hi_ok && wv <= `STP_MAX_VDIFF;
      `STP_IDX_RSVA:    in_range = hi_ok && wv == 16'h0000;
      `STP_IDX_RSVB:    in_range = hi_ok && wv == 16'h0000;
      `STP_IDX_HOMEPOS: in_range = (pwdata[31:16] == {16{pwdata[15]}});
      `STP_IDX_DWELL:   in_range = hi_ok && wv >= `STP_MIN_DWELL && wv <= `STP_MAX_DWELL;
      `STP_IDX_TRQCAP:  in_range = hi_ok && wv >= `STP_MIN_TRQCAP && wv <= `STP_MAX_TRQCAP;
      `STP_IDX_STATUS:  in_range = 1'b0;
      `STP_IDX_TUNE_INER: in_range = 1'b0;
      `STP_IDX_TUNE_PG2:  in_range = 1'b0;
      `STP_IDX_TUNE_VG1:  in_range = 1'b0;
      `STP_IDX_TUNE_VG2:  in_range = 1'b0;
      `STP_IDX_TUNE_VIC:  in_range = 1'b0;
      default:          in_range = hi_ok;
    endcase
  end

  wire do_wr = wr & mapped & in_range;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (~mapped | (pwrite & ~in_range));
      if (rd_ph) begin
        prdata <= {16'h0000, rdv};
      end
    end
  end

  // ----------------------------------------
  // parameter storage
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brake_release_delay     <= `STP_RST_BRAKE;
      inertia_ratio_setting   <= `STP_RST_INERTIA;
      position_gain_second    <= `STP_RST_PGAIN2;
      speed_gain_first        <= `STP_RST_VGAIN1;
      speed_gain_second       <= `STP_RST_VGAIN2;
      speed_integral_time     <= `STP_RST_VINT;
      speed_differential_comp <= `STP_RST_VDIFF;
      home_position_value     <= `STP_RST_HOMEPOS;
      post_dog_travel         <= `STP_RST_DOGTRAV;
      stopper_dwell_time      <= `STP_RST_DWELL;
      stopper_torque_cap      <= `STP_RST_TRQCAP;
      ctrl                    <= 3'b000;
    end else begin
      // tuning results win over a software write
      if (tuning && tune_valid) begin
        inertia_ratio_setting <= tune_inertia;
        position_gain_second  <= tune_pgain2;
        speed_gain_first      <= tune_vgain1;
        speed_gain_second     <= tune_vgain2;
        speed_integral_time   <= tune_vint;
      end
      if (do_wr) begin
        case (idx)
          `STP_IDX_BRAKE:   brake_release_delay     <= wv;
          `STP_IDX_INERTIA: if (!tuning) inertia_ratio_setting <= wv;
          `STP_IDX_PGAIN2:  if (!tuning) position_gain_second  <= wv;
          `STP_IDX_VGAIN1:  if (!tuning) speed_gain_first      <= wv;
          `STP_IDX_VGAIN2:  if (!tuning) speed_gain_second     <= wv;
          `STP_IDX_VINT:    if (!tuning) speed_integral_time   <= wv;
          `STP_IDX_VDIFF:   speed_differential_comp <= wv;
          `STP_IDX_HOMEPOS: home_position_value     <= wv;
          `STP_IDX_DOGTRAV: post_dog_travel         <= wv;
          `STP_IDX_DWELL:   stopper_dwell_time      <= wv;
          `STP_IDX_TRQCAP:  stopper_torque_cap      <= wv;
          `STP_IDX_CTRL:    ctrl <= wv[2:0];
          default:          ctrl <= ctrl;
        endcase
      end else if (ctrl[`STP_CTRL_HOMESTART] && state != ST_IDLE) begin
        // start bit clears once the sequence has left idle
        ctrl[`STP_CTRL_HOMESTART] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // last tuning results, read only
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_tune_inertia <= 16'h0000;
      last_tune_pgain2  <= 16'h0000;
      last_tune_vgain1  <= 16'h0000;
      last_tune_vgain2  <= 16'h0000;
      last_tune_vint    <= 16'h0000;
    end else if (tuning && tune_valid) begin
      last_tune_inertia <= tune_inertia;
      last_tune_pgain2  <= tune_pgain2;
      last_tune_vgain1  <= tune_vgain1;
      last_tune_vgain2  <= tune_vgain2;
      last_tune_vint    <= tune_vint;
    end
  end

  // ----------------------------------------
  // brake sequence and proportion control
  // ----------------------------------------
  stp_ms_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_brake_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    // falling interlock starts the delay, rising aborts it
    .start    (brake_prev & ~brake_interlock_out),
    .abort    (brake_interlock_out),
    .ms_count (brake_release_delay),
    .busy     (brake_busy),
    .done     (brake_done)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brake_prev        <= 1'b0;
      base_shutoff      <= 1'b0;
      diff_comp_applied <= 16'h0000;
    end else begin
      brake_prev <= brake_interlock_out;
      if (brake_interlock_out) begin
        base_shutoff <= 1'b0;
      end else if (brake_done) begin
        base_shutoff <= 1'b1;
      end
      diff_comp_applied <= proportion_control_in ? speed_differential_comp : 16'h0000;
    end
  end

  // ----------------------------------------
  // home position return
  // ----------------------------------------
  // dropping torque during the dwell goes back to seek
  wire dwell_start = (state == ST_SEEK) & ctrl[`STP_CTRL_STOPPER] & torque_reached;

  stp_ms_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_dwell_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (dwell_start),
    .abort    ((state == ST_DWELL) & ~torque_reached),
    .ms_count (stopper_dwell_time),
    .busy     (dwell_busy),
    .done     (dwell_done)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state            <= ST_IDLE;
      travel_left      <= 16'h0000;
      homing_busy      <= 1'b0;
      torque_limit_en  <= 1'b0;
      torque_limit_pct <= 16'h0064;
      home_set         <= 1'b0;
      current_position <= 16'h0000;
    end else begin
      home_set <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (ctrl[`STP_CTRL_HOMESTART]) begin
            state           <= ST_SEEK;
            homing_busy     <= 1'b1;
            torque_limit_en <= ctrl[`STP_CTRL_STOPPER];
            torque_limit_pct <= ctrl[`STP_CTRL_STOPPER] ? stopper_torque_cap : 16'h0064;
          end
        end
        ST_SEEK: begin
          if (dwell_start) begin
            state <= ST_DWELL;
          end else if (!ctrl[`STP_CTRL_STOPPER] && dog_detected) begin
            travel_left <= post_dog_travel;
            state       <= ST_TRAVL;
          end
        end
        ST_TRAVL: begin
          if (travel_left == 16'h0000) begin
            state            <= ST_IDLE;
            homing_busy      <= 1'b0;
            home_set         <= 1'b1;
            current_position <= home_position_value;
          end else if (travel_pulse) begin
            travel_left <= travel_left - 16'h0001;
          end
        end
        ST_DWELL: begin
          if (dwell_done) begin
            state            <= ST_IDLE;
            homing_busy      <= 1'b0;
            torque_limit_en  <= 1'b0;
            torque_limit_pct <= 16'h0064;
            home_set         <= 1'b1;
            current_position <= home_position_value;
          end else if (!dwell_busy) begin
            state <= ST_SEEK;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // stp_servo_params

// ### verification/stp_drive_model.sv
// ----------------------------------------
// motor drive stage seen by the home logic
// ----------------------------------------
module stp_drive_model #(
  parameter GAP = 3
) (
  // clock and reset
  input  wire  pclk,
  input  wire  presetn,
  // from the block
  input  wire  homing_busy,
  input  wire  torque_limit_en,
  // to the block
  output logic dog_detected,
  output logic travel_pulse,
  output logic torque_reached
);
  integer cnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn || !homing_busy) begin
      cnt <= 0;
      dog_detected <= 1'b0;
      travel_pulse <= 1'b0;
      torque_reached <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      dog_detected <= !torque_limit_en && cnt >= 4;
      travel_pulse <= dog_detected && (cnt % GAP == 0);
      torque_reached <= torque_limit_en && cnt >= 8;
    end
  end
endmodule // stp_drive_model

// ### verification/stp_servo_params_chk.sv
// ----------------------------------------
// port checker
// ----------------------------------------
module stp_params_chk (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  // bus
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire        pready,
  input wire        pslverr,
  // device side
  input wire        brake_interlock_out,
  input wire        base_shutoff,
  input wire        proportion_control_in,
  input wire [15:0] diff_comp_applied,
  input wire        tune_valid,
  input wire        homing_busy,
  input wire        torque_limit_en,
  input wire [15:0] torque_limit_pct,
  input wire        home_set,
  input wire [15:0] position_gain_second,
  input wire [15:0] speed_gain_first
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_pc_off;
    !proportion_control_in ##1 !proportion_control_in;
  endsequence
  ready_after_setup_a: assert property (s_setup |=> pready) else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  shutoff_needs_low_a: assert property ($rose(base_shutoff) |-> !brake_interlock_out &&
    !$past(brake_interlock_out)) else $error("shutoff with interlock on");
  shutoff_clear_a: assert property (brake_interlock_out |=> !base_shutoff) else $error("shutoff kept");
  comp_off_a: assert property (s_pc_off |-> diff_comp_applied == 16'h0000) else $error("comp applied");
  home_pulse_a: assert property (home_set |=> !home_set) else $error("home pulse long");
  home_from_busy_a: assert property ($rose(home_set) |-> $past(homing_busy)) else $error("home idle");
  torque_cap_a: assert property (torque_limit_en |-> torque_limit_pct >= 16'h0001 &&
    torque_limit_pct <= 16'h0064) else $error("torque cap range");
  gains_hold_a: assert property (!(psel && penable && pwrite) && !$past(psel && penable && pwrite) &&
    !tune_valid && !$past(tune_valid) |=> $stable({position_gain_second, speed_gain_first}))
    else $error("gain changed");
endmodule // stp_params_chk
bind stp_servo_params stp_params_chk i_stp_params_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .brake_interlock_out(brake_interlock_out), .base_shutoff(base_shutoff),
  .proportion_control_in(proportion_control_in), .diff_comp_applied(diff_comp_applied),
  .tune_valid(tune_valid), .homing_busy(homing_busy), .torque_limit_en(torque_limit_en),
  .torque_limit_pct(torque_limit_pct), .home_set(home_set),
  .position_gain_second(position_gain_second), .speed_gain_first(speed_gain_first));

// ### verification/tb.sv
`include "stp_map.vh"
// ----------------------------------------
// testbench
// ----------------------------------------
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, bio, bso, pc, tv, dog, tp, tr, hb, te, hs;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] dca, tpct, cpos, ti, tp2, tg1, tg2, tvi, o_in, o_pg, o_g1, o_g2, o_vi;
  integer miscompares = 0, checked = 0;
  stp_servo_params #(.MS_CYCLES(10)) i_stp_servo_params (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .brake_interlock_out(bio), .base_shutoff(bso), .proportion_control_in(pc),
    .diff_comp_applied(dca), .tune_valid(tv), .tune_inertia(ti), .tune_pgain2(tp2), .tune_vgain1(tg1),
    .tune_vgain2(tg2), .tune_vint(tvi), .dog_detected(dog), .travel_pulse(tp), .torque_reached(tr),
    .homing_busy(hb), .torque_limit_en(te), .torque_limit_pct(tpct), .home_set(hs), .current_position(cpos),
    .inertia_ratio_setting(o_in), .position_gain_second(o_pg), .speed_gain_first(o_g1),
    .speed_gain_second(o_g2), .speed_integral_time(o_vi));
  stp_drive_model i_stp_drive_model (.pclk(pclk), .presetn(presetn), .homing_busy(hb),
    .torque_limit_en(te), .dog_detected(dog), .travel_pulse(tp), .torque_reached(tr));
  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: %s %h/%h", $time, m, g, e);
    end
  endtask
  task tmo;
    chk(0, 1, "timeout");
    report_and_stop;
  endtask
  function [11:0] ad(input [7:0] i);
    ad = {2'b00, i, 2'b00};
  endfunction
  task apb(input [7:0] i, input w, input [31:0] d, input ee, input [31:0] ed);
    integer n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad(i);
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) tmo;
    chk(pslverr, ee, "pslverr");
    if (!w) chk(prdata, ed, "prdata");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input [7:0] i, input [31:0] d, input e);
    apb(i, 1'b1, d, e, 32'h0);
  endtask
  task rd(input [7:0] i, input [15:0] v);
    apb(i, 1'b0, 32'h0, 1'b0, {16'h0, v});
  endtask
  task rng(input [7:0] i, input [15:0] lo, input [15:0] hi);
    if (lo != 16'h0) wr(i, {16'h0, lo} - 32'h1, 1'b1);
    wr(i, lo, 1'b0);
    wr(i, {16'h0, hi} + 32'h1, 1'b1);
    rd(i, lo);
    wr(i, hi, 1'b0);
    rd(i, hi);
  endtask
  task t_defaults;
    rd(`STP_IDX_BRAKE, `STP_RST_BRAKE);
    rd(`STP_IDX_INERTIA, `STP_RST_INERTIA);
    rd(`STP_IDX_PGAIN2, `STP_RST_PGAIN2);
    rd(`STP_IDX_VGAIN1, `STP_RST_VGAIN1);
    rd(`STP_IDX_VGAIN2, `STP_RST_VGAIN2);
    rd(`STP_IDX_VINT, `STP_RST_VINT);
    rd(`STP_IDX_VDIFF, `STP_RST_VDIFF);
    rd(`STP_IDX_RSVA, 16'h0000);
    rd(`STP_IDX_HOMEPOS, `STP_RST_HOMEPOS);
    rd(`STP_IDX_DOGTRAV, `STP_RST_DOGTRAV);
    rd(`STP_IDX_DWELL, `STP_RST_DWELL);
    rd(`STP_IDX_TRQCAP, `STP_RST_TRQCAP);
    chk(o_g2, `STP_RST_VGAIN2, "gain out");
    $display("test defaults done");
  endtask
  task t_range;
    rng(`STP_IDX_BRAKE, 16'h0000, `STP_MAX_BRAKE);
    rng(`STP_IDX_INERTIA, `STP_MIN_INERTIA, `STP_MAX_INERTIA);
    rng(`STP_IDX_PGAIN2, `STP_MIN_PGAIN2, `STP_MAX_PGAIN2);
    rng(`STP_IDX_VGAIN1, `STP_MIN_VGAIN1, `STP_MAX_VGAIN1);
    rng(`STP_IDX_VGAIN2, `STP_MIN_VGAIN2, `STP_MAX_VGAIN2);
    rng(`STP_IDX_VINT, `STP_MIN_VINT, `STP_MAX_VINT);
    rng(`STP_IDX_VDIFF, 16'h0000, `STP_MAX_VDIFF);
    rng(`STP_IDX_DOGTRAV, 16'h0000, 16'hFFFF);
    rng(`STP_IDX_DWELL, `STP_MIN_DWELL, `STP_MAX_DWELL);
    rng(`STP_IDX_TRQCAP, `STP_MIN_TRQCAP, `STP_MAX_TRQCAP);
    wr(`STP_IDX_HOMEPOS, 32'h0001_0000, 1'b1);
    wr(`STP_IDX_RSVB, 32'h0, 1'b0);
    wr(`STP_IDX_RSVB, 32'h1, 1'b1);
    wr(`STP_IDX_STATUS, 32'h0, 1'b1);
    wr(8'd50, 32'h0, 1'b1);
    chk(o_pg, `STP_MAX_PGAIN2, "gain out");
    $display("test range done");
  endtask
  task t_brake(input [15:0] d);
    integer n;
    wr(`STP_IDX_BRAKE, d, 1'b0);
    bio <= 1'b0;
    n = 0;
    do begin @(posedge pclk); n++; end while (bso !== 1'b1 && n < 2000);
    if (n >= 2000) tmo;
    chk(n >= d * 10 && n <= d * 10 + 3, 1, "brake delay");
    rd(`STP_IDX_STATUS, 16'h0001);
    bio <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(bso, 0, "shutoff clear");
    $display("test brake done");
  endtask
  task t_pc;
    pc <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(dca, `STP_MAX_VDIFF, "comp on");
    pc <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(dca, 16'h0, "comp off");
    $display("test comp done");
  endtask
  task t_tune;
    wr(`STP_IDX_CTRL, 32'h1, 1'b0);
    {ti, tp2, tg1, tg2, tvi} <= {16'h000B, 16'h000C, 16'h000D, 16'h000E, 16'h000F};
    tv <= 1'b1;
    @(posedge pclk);
    tv <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({o_in, o_pg, o_g1, o_g2, o_vi} == 80'h000B000C000D000E000F, 1, "tune");
    rd(`STP_IDX_TUNE_PG2, 16'h000C);
    rd(`STP_IDX_CTRL, 16'h0001);
    wr(`STP_IDX_TUNE_VIC, 32'h0, 1'b1);
    wr(`STP_IDX_PGAIN2, 32'h5, 1'b0);
    chk(o_pg, 16'h000C, "tune wins");
    wr(`STP_IDX_CTRL, 32'h0, 1'b0);
    $display("test tune done");
  endtask
  task t_count;
    integer n, p;
    wr(`STP_IDX_DOGTRAV, 32'h4, 1'b0);
    wr(`STP_IDX_HOMEPOS, 32'hFFFF_FFFB, 1'b0);
    wr(`STP_IDX_CTRL, 32'h4, 1'b0);
    n = 0;
    p = 0;
    do begin @(posedge pclk); n++; if (tp === 1'b1) p++; end while (hs !== 1'b1 && n < 500);
    if (n >= 500) tmo;
    @(posedge pclk);
    chk(p, 4, "travel");
    chk(cpos, 16'hFFFB, "position");
    chk(hb, 0, "busy off");
    $display("test count home done");
  endtask
  task t_stop;
    integer n;
    wr(`STP_IDX_TRQCAP, 32'h14, 1'b0);
    wr(`STP_IDX_DWELL, 32'h5, 1'b0);
    wr(`STP_IDX_CTRL, 32'h6, 1'b0);
    repeat (2) @(posedge pclk);
    chk({te, tpct}, {1'b1, 16'h0014}, "cap");
    n = 0;
    do begin @(posedge pclk); n++; end while (tr !== 1'b1 && n < 100);
    if (n >= 100) tmo;
    n = 0;
    do begin @(posedge pclk); n++; end while (hs !== 1'b1 && n < 200);
    if (n >= 200) tmo;
    chk(n >= 50 && n <= 53, 1, "dwell");
    repeat (2) @(posedge pclk);
    chk(te, 0, "cap off");
    $display("test stopper home done");
  endtask
  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pc, tv, ti, tp2, tg1, tg2, tvi} = '0;
    bio = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_defaults;
    t_range;
    t_brake(16'h3);
    t_brake(16'h0);
    t_pc;
    t_tune;
    t_count;
    t_stop;
    report_and_stop;
  end
endmodule // tb
